//--- rtl/ref_sync_params.svh
// constants of the reference point synchronisation block
// assumes byte addresses on a 32-bit ahb-lite bus, one word per register
`ifndef REF_SYNC_PARAMS_SVH
`define REF_SYNC_PARAMS_SVH
`define ADDR_CTRL 8'h00
`define ADDR_CONFIG 8'h04
`define ADDR_ZERO_OFFSET 8'h08
`define ADDR_STATUS 8'h0c
`define ADDR_EVENTS 8'h10
`define ADDR_ACTUAL 8'h14
`define ADDR_FINAL 8'h18
`define CTRL_GATE_BIT 0
`define CTRL_MANUAL_BIT 1
`define CTRL_CMD1_BIT 2
`define CTRL_CMD2_BIT 3
`define CTRL_HWREF_BIT 4
`define CTRL_SOFT_BIT 5
`define CTRL_EDGE_BIT 6
`define CTRL_MASK_BIT 7
`define CTRL_POS_LSB 8
`define CONFIG_MODE_LSB 0
`define CONFIG_BACKLASH_BIT 2
`define STAT_SYNC_BIT 0
`define STAT_RANGE1_BIT 1
`define STAT_RANGE2_BIT 2
`define STAT_RANGE3_BIT 3
`define STAT_DIR_BIT 4
`define STAT_OUT1_BIT 5
`define STAT_OUT2_BIT 6
`define STAT_REJECT_BIT 7
`define STAT_MONITOR_BIT 8
`define STAT_APPROACH_BIT 9
`define STAT_POS_LSB 16
`define EV_CONTACT_BIT 0
`define EV_REFERENCE_BIT 1
`define POS_INVALID 8'hff
`define POS_RESET 8'hff
`define MODE_SEPARATE 2'h0
`define MODE_COLLECTIVE 2'h1
`define MODE_DIRECTION 2'h2
`define MODE_RESET 2'h0
`define OFFSET_RESET 32'h0000_0000
`define ACTUAL_RESET 32'h0000_0000
`endif

//--- rtl/ref_sync_pkg.sv
// types of the reference point synchronisation block
// assumes ref_sync_params.svh is on the include path
`include "ref_sync_params.svh"
package ref_sync_pkg;
  typedef enum logic [2:0]
  {
    ST_OFF,
    ST_SEEK,
    ST_CONTACT,
    ST_ZERO,
    ST_DONE
  } approach_state_t;

  typedef struct packed
  {
    logic [1:0] a_s;
    logic [1:0] b_s;
    logic [1:0] z_s;
    logic [1:0] c_s;
    logic a_d;
    logic zq_d;
    logic c_d;
    approach_state_t st;
    logic gate;
    logic manual;
    logic cmd1;
    logic cmd2;
    logic hwref;
    logic edge_sel;
    logic mask;
    logic [7:0] pos;
    logic [1:0] mode;
    logic backlash;
    logic [31:0] offset;
    logic [31:0] actual;
    logic [31:0] final_v;
    logic sync;
    logic range1;
    logic range2;
    logic range3;
    logic dir;
    logic dir_up;
    logic exit_down;
    logic out1;
    logic out2;
    logic reject;
    logic monitor;
    logic ev_contact;
    logic ev_ref;
    logic pend;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] rdata;
    logic ready;
  } state_t;
endpackage

//--- rtl/ref_sync_control.sv
// reference point synchronisation controller for one encoder channel
// assumes a single ahb-lite master, encoder and contact pins asynchronous
// What this block does
// - positioning is allowed only once the actual value is synchronised
// - every synchronisation loads the last written zero offset
// - reference point is the first zero mark after the contact signal
// - backlash compensation syncs only when contact is left ascending
// - zero mark counts only while both quadrature tracks are high
// - hardware select enters approach; clearing it exits or aborts
// - gate bit low holds both drive outputs off
// - manual bit picks host commands, else internal sequencer drives
// - command bits set or reset outputs; illegal pairs are rejected
// - approach may be selected only while outputs are disabled
// - accepting approach clears sync, sets ranges, direction, pos 255
// - contact reached clears range one and, outside direction mode, switches to creep
// - leaving the contact sets range one again
// - zero mark resets outputs, syncs, loads offset, clears range two
// - deselecting approach sets range two back to one
// - quitting with select and gate both low starts no monitoring
// - collective mode: both on, first off at contact, second at ref
// - edge mode syncs on contact rise, captures final value on fall
// - event flags stay set until the event register is read
//
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "ref_sync_params.svh"
module ref_sync_control
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_z,
  input wire logic contact_in,
  output logic drive_output_one,
  output logic drive_output_two,
  output logic positioning_allowed,
  output logic zero_monitor_active
);
  import ref_sync_pkg::*;

  state_t r;
  state_t n;

  always_comb
  begin
    logic a_q;
    logic b_q;
    logic z_q;
    logic c_q;
    logic zq;
    logic c_rise;
    logic c_fall;
    logic wr_ctrl;
    logic rd_ev;
    logic rd_stat;
    logic load;
    logic set_cev;
    logic set_rev;
    logic o1;
    logic o2;
    logic [31:0] w;
    n = r;
    load = 1'b0;
    set_cev = 1'b0;
    set_rev = 1'b0;
    o1 = 1'b0;
    o2 = 1'b0;
    w = hwdata;
    // only the second stage is read beyond the synchroniser
    n.a_s = {r.a_s[0], enc_a};
    n.b_s = {r.b_s[0], enc_b};
    n.z_s = {r.z_s[0], enc_z};
    n.c_s = {r.c_s[0], contact_in};
    a_q = r.a_s[1];
    b_q = r.b_s[1];
    z_q = r.z_s[1];
    c_q = r.c_s[1];
    zq = z_q & a_q & b_q;
    n.a_d = a_q;
    n.zq_d = zq;
    n.c_d = c_q;
    c_rise = c_q & ~r.c_d;
    c_fall = ~c_q & r.c_d;

    // one count per rising a edge; b level gives the direction
    if (a_q & ~r.a_d)
    begin
      n.dir_up = ~b_q;
      n.actual = b_q ? r.actual - 32'h1 : r.actual + 32'h1;
    end

    // bus: every transfer takes one wait state so hrdata comes from a flop
    n.ready = 1'b1;
    n.pend = 1'b0;
    if (hsel & htrans[1] & hready)
    begin
      n.pend = 1'b1;
      n.pwrite = hwrite;
      n.paddr = haddr[7:0];
      n.ready = 1'b0;
    end
    wr_ctrl = r.pend & r.pwrite & (r.paddr == `ADDR_CTRL);
    rd_ev = r.pend & ~r.pwrite & (r.paddr == `ADDR_EVENTS);
    rd_stat = r.pend & ~r.pwrite & (r.paddr == `ADDR_STATUS);
    if (rd_ev)
    begin
      n.ev_contact = 1'b0;
      n.ev_ref = 1'b0;
    end
    if (rd_stat)
    begin
      n.reject = 1'b0;
    end
    if (r.pend & r.pwrite)
    begin
      if (r.paddr == `ADDR_CONFIG)
      begin
        n.mode = w[`CONFIG_MODE_LSB +: 2];
        n.backlash = w[`CONFIG_BACKLASH_BIT];
      end
      else if (r.paddr == `ADDR_ZERO_OFFSET)
      begin
        n.offset = w;
      end
    end

    // sequencer
    case (r.st)
      ST_SEEK:
      begin
        // a contact already active at the start counts at once
        if (c_q)
        begin
          n.st = ST_CONTACT;
          n.range1 = 1'b0;
          set_cev = 1'b1;
        end
      end
      ST_CONTACT:
      begin
        if (c_fall)
        begin
          n.st = ST_ZERO;
          n.range1 = 1'b1;
          n.exit_down = ~r.dir_up;
        end
      end
      ST_ZERO:
      begin
        if (zq & ~r.zq_d)
        begin
          load = 1'b1;
          // leaving downward with backlash only resets the value
          if (~(r.backlash & r.exit_down))
          begin
            n.st = ST_DONE;
            n.sync = 1'b1;
            n.range2 = 1'b0;
            set_rev = 1'b1;
          end
        end
      end
      default:
      begin
      end
    endcase

    if (r.edge_sel & (r.st == ST_OFF))
    begin
      if (c_rise)
      begin
        load = 1'b1;
        n.sync = 1'b1;
      end
      if (c_fall)
      begin
        n.final_v = r.actual;
      end
    end

    // a control write is applied as one word, after the sequencer
    if (wr_ctrl)
    begin
      n.gate = w[`CTRL_GATE_BIT];
      n.manual = w[`CTRL_MANUAL_BIT];
      n.mask = w[`CTRL_MASK_BIT];
      n.pos = w[`CTRL_POS_LSB +: 8];
      if ((r.mode == `MODE_DIRECTION) & w[`CTRL_CMD1_BIT]
          & w[`CTRL_CMD2_BIT])
      begin
        n.reject = 1'b1;
      end
      else
      begin
        n.cmd1 = w[`CTRL_CMD1_BIT];
        n.cmd2 = w[`CTRL_CMD2_BIT];
      end
      if (w[`CTRL_HWREF_BIT] & ~r.hwref)
      begin
        if (r.out1 | r.out2)
        begin
          n.reject = 1'b1;
        end
        else
        begin
          n.hwref = 1'b1;
          n.st = ST_SEEK;
          n.sync = 1'b0;
          n.range1 = 1'b1;
          n.range2 = 1'b1;
          n.range3 = 1'b1;
          n.dir = 1'b1;
          n.pos = `POS_INVALID;
          n.monitor = 1'b0;
        end
      end
      else if (~w[`CTRL_HWREF_BIT] & r.hwref)
      begin
        n.hwref = 1'b0;
        n.st = ST_OFF;
        n.range2 = 1'b1;
        n.range1 = 1'b1;
        n.monitor = (r.st == ST_DONE) & w[`CTRL_GATE_BIT];
      end
      if (w[`CTRL_EDGE_BIT] & ~r.edge_sel)
      begin
        n.sync = 1'b0;
        n.range1 = 1'b1;
        n.range2 = 1'b1;
        n.range3 = 1'b1;
        n.dir = 1'b1;
        n.gate = 1'b0;
      end
      n.edge_sel = w[`CTRL_EDGE_BIT];
      if (w[`CTRL_SOFT_BIT])
      begin
        load = 1'b1;
        n.sync = 1'b1;
      end
    end

    if (load)
    begin
      n.actual = r.offset;
    end
    if (set_cev & ~r.mask)
    begin
      n.ev_contact = 1'b1;
    end
    if (set_rev & ~r.mask)
    begin
      n.ev_ref = 1'b1;
    end

    // drive outputs from the state being entered
    case (n.st)
      ST_SEEK:
      begin
        o1 = (n.mode != `MODE_DIRECTION) | n.cmd1;
        o2 = (n.mode == `MODE_COLLECTIVE)
             | ((n.mode == `MODE_DIRECTION) & n.cmd2);
      end
      ST_CONTACT, ST_ZERO:
      begin
        o1 = (n.mode == `MODE_DIRECTION) & n.cmd1;
        o2 = (n.mode != `MODE_DIRECTION) | n.cmd2;
      end
      default:
      begin
        o1 = 1'b0;
        o2 = 1'b0;
      end
    endcase
    if (n.manual)
    begin
      o1 = n.cmd1;
      o2 = n.cmd2;
    end
    n.out1 = n.gate & o1;
    n.out2 = n.gate & o2;

    // read data for the cycle that ends the data phase
    n.rdata = 32'h0000_0000;
    if (r.pend & ~r.pwrite)
    begin
      if (r.paddr == `ADDR_CTRL)
      begin
        n.rdata[`CTRL_GATE_BIT] = r.gate;
        n.rdata[`CTRL_MANUAL_BIT] = r.manual;
        n.rdata[`CTRL_CMD1_BIT] = r.cmd1;
        n.rdata[`CTRL_CMD2_BIT] = r.cmd2;
        n.rdata[`CTRL_HWREF_BIT] = r.hwref;
        n.rdata[`CTRL_EDGE_BIT] = r.edge_sel;
        n.rdata[`CTRL_MASK_BIT] = r.mask;
        n.rdata[`CTRL_POS_LSB +: 8] = r.pos;
      end
      else if (r.paddr == `ADDR_CONFIG)
      begin
        n.rdata[`CONFIG_MODE_LSB +: 2] = r.mode;
        n.rdata[`CONFIG_BACKLASH_BIT] = r.backlash;
      end
      else if (r.paddr == `ADDR_ZERO_OFFSET)
      begin
        n.rdata = r.offset;
      end
      else if (r.paddr == `ADDR_STATUS)
      begin
        n.rdata[`STAT_SYNC_BIT] = r.sync;
        n.rdata[`STAT_RANGE1_BIT] = r.range1;
        n.rdata[`STAT_RANGE2_BIT] = r.range2;
        n.rdata[`STAT_RANGE3_BIT] = r.range3;
        n.rdata[`STAT_DIR_BIT] = r.dir;
        n.rdata[`STAT_OUT1_BIT] = r.out1;
        n.rdata[`STAT_OUT2_BIT] = r.out2;
        n.rdata[`STAT_REJECT_BIT] = r.reject;
        n.rdata[`STAT_MONITOR_BIT] = r.monitor;
        n.rdata[`STAT_APPROACH_BIT] = r.hwref;
        n.rdata[`STAT_POS_LSB +: 8] = r.pos;
      end
      else if (r.paddr == `ADDR_EVENTS)
      begin
        n.rdata[`EV_CONTACT_BIT] = r.ev_contact;
        n.rdata[`EV_REFERENCE_BIT] = r.ev_ref;
      end
      else if (r.paddr == `ADDR_ACTUAL)
      begin
        n.rdata = r.actual;
      end
      else if (r.paddr == `ADDR_FINAL)
      begin
        n.rdata = r.final_v;
      end
      else
      begin
        n.rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r <= '0;
      r.st <= ST_OFF;
      r.pos <= `POS_RESET;
      r.mode <= `MODE_RESET;
      r.offset <= `OFFSET_RESET;
      r.actual <= `ACTUAL_RESET;
      r.range1 <= 1'b1;
      r.range2 <= 1'b1;
      r.range3 <= 1'b1;
      r.dir <= 1'b1;
      r.ready <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end

  assign hreadyout = r.ready;
  assign hresp = 1'b0;
  assign hrdata = r.rdata;
  assign drive_output_one = r.out1;
  assign drive_output_two = r.out2;
  assign positioning_allowed = r.sync;
  assign zero_monitor_active = r.monitor;
endmodule

//--- testbench/ref_sync_assertions.sv
// port checker for the reference sync controller
// assumes one ahb-lite master writing whole control words
`timescale 1ns/1ps
module ref_sync_assertions
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic contact_in,
  input wire logic drive_output_one,
  input wire logic drive_output_two,
  input wire logic positioning_allowed,
  input wire logic zero_monitor_active
);
  logic pend;
  logic [7:0] pa;
  logic [7:0] ctl;
  logic [1:0] cfg;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // shadow of the last words written, taken in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend <= 1'b0;
      pa <= 8'h00;
      ctl <= 8'h00;
      cfg <= 2'h0;
    end
    else
    begin
      pend <= hsel && htrans[1] && hready && hwrite;
      pa <= haddr[7:0];
      if (pend && pa == 8'h00)
        ctl <= hwdata[7:0];
      if (pend && pa == 8'h04)
        cfg <= hwdata[1:0];
    end
  end
  one_wait_a: assert property (
    hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
    else $error("not one wait state");
  gate_off_a: assert property (
    !ctl[0] |-> !drive_output_one && !drive_output_two)
    else $error("output on with gate off");
  manual_follow_a: assert property (
    ctl[0] && ctl[1] && !ctl[6] && !(ctl[2] && ctl[3]) |->
    drive_output_one == ctl[2] && drive_output_two == ctl[3])
    else $error("manual outputs differ from commands");
  approach_clears_a: assert property (
    $rose(ctl[4]) && !$past(drive_output_one) &&
    !$past(drive_output_two) |-> !positioning_allowed)
    else $error("sync kept on approach select");
  sync_loss_a: assert property (
    $fell(positioning_allowed) |-> $rose(ctl[4]) || $rose(ctl[6]))
    else $error("sync lost without cause");
  creep_switch_a: assert property (
    ctl[0] && !ctl[1] && ctl[4] && cfg != 2'h2 && drive_output_one &&
    $rose(contact_in) |-> ##[1:6] (!drive_output_one && drive_output_two))
    else $error("no creep at contact");
  ref_stops_a: assert property (
    $rose(positioning_allowed) && ctl[4] && !ctl[1] && !ctl[5] |->
    ##[0:1] (!drive_output_one && !drive_output_two))
    else $error("output on after reference");
  quit_monitor_a: assert property (
    $fell(ctl[4]) && !ctl[0] |-> !zero_monitor_active)
    else $error("monitor on after quit with gate off");
  monitor_cause_a: assert property (
    $rose(zero_monitor_active) |-> $fell(ctl[4]) && ctl[0])
    else $error("monitor started without quit");
endmodule
bind ref_sync_control ref_sync_assertions u_chk
(
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hreadyout, .contact_in, .drive_output_one, .drive_output_two,
  .positioning_allowed, .zero_monitor_active
);

//--- testbench/encoder_model.sv
// encoder, contact switch and drive on one axis
// assumes drive outputs move the axis, upward unless reverse, fast on one
`timescale 1ns/1ps
module encoder_model
(
  input wire logic hclk,
  input wire logic drive_one,
  input wire logic drive_two,
  input wire logic reverse,
  output logic enc_a,
  output logic enc_b,
  output logic enc_z,
  output logic contact
);
  logic [15:0] pos;
  logic [3:0] tick;
  initial
  begin
    pos = 16'h0000;
    tick = 4'h0;
  end
  // axis stops once the drive is off, so no zero mark follows the sync at the reference point
  always @(posedge hclk)
  begin
    tick <= tick + 4'h1;
    if ((drive_one && tick[1:0] == 2'h0) || (drive_two && tick[2:0] == 3'h0))
      pos <= reverse ? pos - 16'h1 : pos + 16'h1;
  end
  assign enc_a = pos[1] ^ pos[0];
  assign enc_b = pos[1];
  // zero mark spans exactly one quarter where both tracks are high
  assign enc_z = pos[4:0] == 5'h02;
  assign contact = pos[6:4] == 3'h3;
endmodule

//--- testbench/tb.sv
// self-checking bench for the reference sync controller
// assumes the ahb-lite map given by ref_sync_params.svh
`timescale 1ns/1ps
module tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout;
  logic [31:0] haddr, hwdata, hrdata, r, dv;
  logic [1:0] htrans;
  logic enc_a, enc_b, enc_z, contact_in;
  logic drive_output_one, drive_output_two;
  logic positioning_allowed, zero_monitor_active;
  logic reverse;
  logic [3:0] wv;
  int failures, compares, cycles;
  assign dv = {30'h0, drive_output_one, drive_output_two};
  assign wv = {contact_in, positioning_allowed, drive_output_two,
    drive_output_one};
  ref_sync_control u_dut
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
    .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z), .contact_in(contact_in),
    .drive_output_one(drive_output_one),
    .drive_output_two(drive_output_two),
    .positioning_allowed(positioning_allowed),
    .zero_monitor_active(zero_monitor_active)
  );
  encoder_model u_enc
  (
    .hclk(hclk), .drive_one(drive_output_one),
    .drive_two(drive_output_two), .reverse(reverse), .enc_a(enc_a),
    .enc_b(enc_b), .enc_z(enc_z), .contact(contact_in)
  );
  task end_of_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(r & m, e);
  endtask
  // bounded wait; a miss shows up in the compare that follows
  task automatic wait_for(input int k, input logic v);
    int n;
    n = 0;
    while (wv[k] !== v && n < 3000)
    begin
      @(posedge hclk);
      n++;
    end
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      end_of_test();
    end
  end
  initial
  begin
    {hresetn, hsel, hwrite, haddr, hwdata, htrans, reverse} = '0;
    {failures, compares, cycles} = '0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h0c, '1, 32'h00ff001e);
    rd(8'h1c, '1, 32'h0);
    chk({31'h0, positioning_allowed}, 32'h0);
    wr(8'h08, 32'h1234);
    wr(8'h00, 32'h20);
    rd(8'h14, '1, 32'h1234);
    chk({31'h0, positioning_allowed}, 32'h1);
    $display("soft sync test done");
    wr(8'h08, 32'h100);
    wr(8'h00, 32'h10);
    chk({31'h0, positioning_allowed}, 32'h0);
    rd(8'h0c, 32'h00ff001f, 32'h00ff001e);
    wr(8'h00, 32'h11);
    chk(dv, 32'h2);
    wait_for(1, 1'b1);
    chk(dv, 32'h1);
    wait_for(2, 1'b1);
    chk(dv, 32'h0);
    rd(8'h14, '1, 32'h100);
    rd(8'h10, '1, 32'h3);
    rd(8'h10, '1, 32'h0);
    rd(8'h0c, 32'h7, 32'h3);
    wr(8'h00, 32'h01);
    rd(8'h0c, 32'h4, 32'h4);
    chk({31'h0, zero_monitor_active}, 32'h1);
    wr(8'h00, 32'h0);
    $display("separate approach test done");
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h10);
    wr(8'h00, 32'h11);
    chk(dv, 32'h3);
    wait_for(0, 1'b0);
    chk(dv, 32'h1);
    wait_for(2, 1'b1);
    chk(dv, 32'h0);
    wr(8'h00, 32'h0);
    chk({31'h0, zero_monitor_active}, 32'h0);
    $display("collective approach test done");
    wr(8'h04, 32'h2);
    wr(8'h00, 32'h14);
    wr(8'h00, 32'h15);
    chk(dv, 32'h2);
    wait_for(2, 1'b1);
    chk(dv, 32'h0);
    rd(8'h10, '1, 32'h3);
    wr(8'h00, 32'h0);
    $display("direction approach test done");
    wr(8'h00, 32'h0e);
    chk(dv, 32'h0);
    wr(8'h00, 32'h07);
    chk(dv, 32'h2);
    wr(8'h00, 32'h0f);
    chk(dv, 32'h2);
    rd(8'h0c, 32'h80, 32'h80);
    wr(8'h00, 32'h0);
    $display("manual output test done");
    wr(8'h00, 32'h12);
    rd(8'h0c, 32'h200, 32'h200);
    chk(dv, 32'h0);
    wr(8'h00, 32'h17);
    chk(dv, 32'h2);
    wr(8'h00, 32'h0);
    $display("manual approach test done");
    wr(8'h00, 32'h40);
    chk({31'h0, positioning_allowed}, 32'h0);
    wr(8'h00, 32'h47);
    wait_for(3, 1'b1);
    wait_for(3, 1'b0);
    wr(8'h00, 32'h40);
    chk({31'h0, positioning_allowed}, 32'h1);
    rd(8'h18, '1, 32'h104);
    wr(8'h00, 32'h0);
    $display("edge sync test done");
    // backlash on and travel downward: zero mark reloads but never syncs
    wr(8'h04, 32'h6);
    reverse <= 1'b1;
    wr(8'h00, 32'h14);
    wr(8'h00, 32'h15);
    wait_for(3, 1'b1);
    wait_for(3, 1'b0);
    repeat (80) @(posedge hclk);
    chk({31'h0, positioning_allowed}, 32'h0);
    chk(dv, 32'h2);
    rd(8'h10, '1, 32'h1);
    wr(8'h00, 32'h04);
    reverse <= 1'b0;
    $display("backlash approach test done");
    end_of_test();
  end
endmodule
